/* rtl/adci_pkg.sv */
// package: register map, field layout and timing constants of the converter control
package adci_pkg;
   // ==========================================================
   // register offsets
   localparam logic [7:0] OFS_CONTROL = 8'hF7;  // converter_control
   localparam logic [7:0] OFS_RESULT_HIGH = 8'hF8;  // converter_result_high
   localparam logic [7:0] OFS_RESULT_LOW = 8'hF9;  // converter_result_low
   localparam logic [7:0] OFS_IRQ_STATUS = 8'hFA;  // sticky events, write one to clear
   localparam logic [7:0] OFS_IRQ_MASK = 8'hFB;  // event enables
   // ==========================================================
   // field positions of converter_control
   localparam int CHAN_MSB = 7;  // channel select field, upper nibble
   localparam int CHAN_LSB = 4;
   localparam int DONE_BIT = 3;  // end-of-conversion flag
   localparam int DIV_MSB = 2;  // clock divider choice
   localparam int DIV_LSB = 1;
   localparam int START_BIT = 0;  // conversion start
   // ==========================================================
   // reset values and codes
   localparam logic [7:0] CONTROL_RESET = 8'hF0;
   localparam logic [3:0] CHAN_LAST = 4'hC;  // highest valid channel code
   localparam logic [3:0] CHAN_OFF = 4'hE;  // power-down code
   localparam logic [1:0] IRQ_RESET = 2'h0;
   // ==========================================================
   // divider ratios for choices 00..11
   localparam logic [4:0] DIV_16 = 5'h10;
   localparam logic [4:0] DIV_12 = 5'h0C;
   localparam logic [4:0] DIV_8 = 5'h08;
   localparam logic [4:0] DIV_4 = 5'h04;
   // ==========================================================
   // interrupt status bits
   localparam int IRQ_DONE_BIT = 0;  // conversion finished
   localparam int IRQ_REJ_BIT = 1;  // start refused because the written channel code powers down
endpackage : adci_pkg

/* rtl/adci_clkdiv.sv */
// converter clock divider: one-cycle tick every selected number of cycles
`timescale 1ns/10ps
module adci_clkdiv (
   input wire logic MCLK,
   input wire logic NRST,
   input wire logic run,
   input wire logic [1:0] sel,
   output logic tick
);
   // ==========================================================
   // divider counter
   logic [4:0] cnt_reg;  // cycles since last tick
   logic [4:0] ratio;  // selected division ratio

   // map the two-bit choice to its ratio
   always_comb begin
      case (sel)
         2'h0: ratio = adci_pkg::DIV_16;
         2'h1: ratio = adci_pkg::DIV_12;
         2'h2: ratio = adci_pkg::DIV_8;
         default: ratio = adci_pkg::DIV_4;
      endcase
   end

   // counter only runs while a conversion is active, so power is saved
   always_ff @(posedge MCLK) begin
      if (!NRST || !run) begin
         cnt_reg <= 5'h00;
         tick <= 1'b0;
      end else if (cnt_reg == ratio - 5'h01) begin
         cnt_reg <= 5'h00;
         tick <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 5'h01;
         tick <= 1'b0;
      end
   end
endmodule : adci_clkdiv

/* rtl/adci_control.sv */
// converter control and status logic with register port and interrupt
// ==========================================================
// Overview of operation
// - upper nibble codes 0..12 select channels
// - code 1110 powers the converter down
// - bit 3 reads 0 busy, 1 done
// - bits 2..1 pick divide 16,12,8,4
// - writing 1 to bit 0 starts
// - control register resets to F0
// - two read-only result bytes, low upper zero
// - valid channel enables, disable code powers down
//
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
module adci_control (
   input wire logic MCLK,
   input wire logic NRST,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   output logic [3:0] CHANNEL,
   output logic CHAN_VALID,
   output logic POWER_DOWN,
   output logic CONV_START,
   output logic CONV_CLK_TICK,
   input wire logic CONV_DONE,
   input wire logic [9:0] CONV_RESULT,
   output logic IRQ
);
   // ==========================================================
   // states of the conversion sequencer
   typedef enum logic [1:0] {
      ADCI_IDLE = 2'b00,
      ADCI_BUSY = 2'b01,
      ADCI_DONE = 2'b11
   } adci_state_e;

   adci_state_e state_reg;  // sequencer state
   logic [3:0] chan_reg;  // channel field
   logic [1:0] div_reg;  // divider choice
   logic done_reg;  // end-of-conversion flag
   logic [9:0] result_reg;  // latched result
   logic [1:0] irq_stat_reg;  // sticky events
   logic [1:0] irq_mask_reg;  // event enables
   logic done_sync1_reg;  // core done, first stage
   logic done_sync2_reg;  // second stage
   logic done_sync3_reg;  // third stage, for agreement
   logic done_filt_reg;  // agreed level of the core done line
   logic done_edge;  // core completion seen
   logic wr_ctl;  // write to control register
   logic start_req;  // start bit written as one
   logic start_ok;  // start accepted
   logic start_rej;  // start refused
   logic start_dly_reg;  // start held back until the channel is routed
   logic tick;  // divider output
   logic [1:0] ev;  // events this cycle

   // a channel code is valid only from 0 to 12
   function automatic logic chan_ok(input logic [3:0] code);
      chan_ok = (code <= adci_pkg::CHAN_LAST);
   endfunction : chan_ok

   // ==========================================================
   // decode
   assign wr_ctl = WR && (ADDR == adci_pkg::OFS_CONTROL);
   assign start_req = wr_ctl && WDATA[adci_pkg::START_BIT];
   // start is judged against the channel being written in the same cycle
   assign start_ok = start_req && chan_ok(WDATA[7:4])
      && (state_reg != ADCI_BUSY);
   assign start_rej = start_req && !chan_ok(WDATA[7:4]);
   // done counts once the second and third stages agree, on its rise only,
   // so a done level left high by the last conversion cannot end a new one
   assign done_edge = done_sync2_reg && done_sync3_reg && !done_filt_reg
      && (state_reg == ADCI_BUSY);
   assign ev = {start_rej, done_edge};

   // ==========================================================
   // divider instance, runs while converting
   adci_clkdiv u_div (
      .MCLK(MCLK),
      .NRST(NRST),
      .run(state_reg == ADCI_BUSY),
      .sel(div_reg),
      .tick(tick)
   );

   // ==========================================================
   // core done synchroniser, the core answers from the analog side
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         done_sync1_reg <= 1'b0;
         done_sync2_reg <= 1'b0;
         done_sync3_reg <= 1'b0;
         done_filt_reg <= 1'b0;
      end else begin
         done_sync1_reg <= CONV_DONE;
         done_sync2_reg <= done_sync1_reg;
         done_sync3_reg <= done_sync2_reg;
         // level only moves once two stages agree, filtering a glitch
         if (done_sync2_reg == done_sync3_reg) begin
            done_filt_reg <= done_sync3_reg;
         end
      end
   end

   // ==========================================================
   // control fields
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         chan_reg <= adci_pkg::CONTROL_RESET[7:4];
         div_reg <= adci_pkg::CONTROL_RESET[2:1];
      end else if (wr_ctl) begin
         chan_reg <= WDATA[adci_pkg::CHAN_MSB:adci_pkg::CHAN_LSB];
         div_reg <= WDATA[adci_pkg::DIV_MSB:adci_pkg::DIV_LSB];
      end
   end

   // ==========================================================
   // sequencer; a conversion is dropped if the channel is turned off
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         state_reg <= ADCI_IDLE;
         done_reg <= adci_pkg::CONTROL_RESET[adci_pkg::DONE_BIT];
      end else begin
         case (state_reg)
            ADCI_IDLE, ADCI_DONE: begin
               if (start_ok) begin
                  state_reg <= ADCI_BUSY;
                  done_reg <= 1'b0;
               end
            end
            ADCI_BUSY: begin
               // a finished conversion is reported even if turned off now
               if (done_edge) begin
                  state_reg <= ADCI_DONE;
                  done_reg <= 1'b1;
               end else if (wr_ctl && !chan_ok(WDATA[7:4])) begin
                  state_reg <= ADCI_IDLE;
               end
            end
            default: state_reg <= ADCI_IDLE;
         endcase
      end
   end

   // ==========================================================
   // result capture
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         result_reg <= 10'h000;
      end else if (done_edge) begin
         result_reg <= CONV_RESULT;
      end
   end

   // ==========================================================
   // outputs to the analog core
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         CHANNEL <= 4'h0;
         CHAN_VALID <= 1'b0;
         POWER_DOWN <= 1'b1;
         CONV_START <= 1'b0;
         start_dly_reg <= 1'b0;
         CONV_CLK_TICK <= 1'b0;
      end else begin
         // no input routed while powered down
         CHANNEL <= chan_ok(chan_reg) ? chan_reg : 4'h0;
         CHAN_VALID <= chan_ok(chan_reg);
         POWER_DOWN <= !chan_ok(chan_reg);
         // start waits one cycle so the core sees it powered and routed
         start_dly_reg <= start_ok;
         CONV_START <= start_dly_reg;
         CONV_CLK_TICK <= tick;
      end
   end

   // ==========================================================
   // interrupt status; set wins over a write-one clear
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         irq_stat_reg <= adci_pkg::IRQ_RESET;
      end else if (WR && ADDR == adci_pkg::OFS_IRQ_STATUS) begin
         irq_stat_reg <= (irq_stat_reg & ~WDATA[1:0]) | ev;
      end else begin
         irq_stat_reg <= irq_stat_reg | ev;
      end
   end

   // interrupt mask
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         irq_mask_reg <= adci_pkg::IRQ_RESET;
      end else if (WR && ADDR == adci_pkg::OFS_IRQ_MASK) begin
         irq_mask_reg <= WDATA[1:0];
      end
   end

   // interrupt line, registered so it lags status by one cycle
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // ==========================================================
   // read port; unmapped offsets read zero
   always_ff @(posedge MCLK) begin
      if (!NRST) begin
         RDATA <= 8'h00;
      end else if (RD) begin
         case (ADDR)
            adci_pkg::OFS_CONTROL:
               RDATA <= {chan_reg, done_reg, div_reg, 1'b0};
            adci_pkg::OFS_RESULT_HIGH: RDATA <= result_reg[9:2];
            adci_pkg::OFS_RESULT_LOW:
               RDATA <= {6'h00, result_reg[1:0]};
            adci_pkg::OFS_IRQ_STATUS: RDATA <= {6'h00, irq_stat_reg};
            adci_pkg::OFS_IRQ_MASK: RDATA <= {6'h00, irq_mask_reg};
            default: RDATA <= 8'h00;
         endcase
      end else begin
         RDATA <= 8'h00;
      end
   end

   // ==========================================================
   // checks
   property p_start_busy;
      @(posedge MCLK) disable iff (!NRST)
         start_ok |=> state_reg == ADCI_BUSY && !done_reg;
   endproperty
   a_start_busy: assert property (p_start_busy)
      else $error("start did not enter busy");

   property p_start_pulse;
      @(posedge MCLK) disable iff (!NRST)
         start_ok |=> ##1 CONV_START ##1 !CONV_START;
   endproperty
   a_start_pulse: assert property (p_start_pulse)
      else $error("start pulse wrong");

   property p_zero_start;
      @(posedge MCLK) disable iff (!NRST)
         wr_ctl && !WDATA[0] |=> ##1 !CONV_START;
   endproperty
   a_zero_start: assert property (p_zero_start)
      else $error("writing zero started");

   property p_off_power;
      @(posedge MCLK) disable iff (!NRST)
         wr_ctl && WDATA[7:4] >= 4'hD |=> ##1 POWER_DOWN && !CHAN_VALID;
   endproperty
   a_off_power: assert property (p_off_power)
      else $error("not powered down");

   property p_rej_start;
      @(posedge MCLK) disable iff (!NRST)
         start_req && WDATA[7:4] > 4'hC |=> state_reg != ADCI_BUSY
            ##1 !CONV_START;
   endproperty
   a_rej_start: assert property (p_rej_start)
      else $error("start accepted while off");

   property p_chan_route;
      @(posedge MCLK) disable iff (!NRST)
         wr_ctl && WDATA[7:4] <= 4'hC |=> ##1 CHANNEL == $past(WDATA[7:4], 2)
            && CHAN_VALID && !POWER_DOWN;
   endproperty
   a_chan_route: assert property (p_chan_route)
      else $error("channel not routed");

   property p_done_flag;
      @(posedge MCLK) disable iff (!NRST)
         done_edge |=> done_reg && state_reg == ADCI_DONE;
   endproperty
   a_done_flag: assert property (p_done_flag)
      else $error("done flag not set");

   property p_low_zero;
      @(posedge MCLK) disable iff (!NRST)
         RD && ADDR == adci_pkg::OFS_RESULT_LOW |=> RDATA[7:2] == 6'h00;
   endproperty
   a_low_zero: assert property (p_low_zero)
      else $error("low result upper bits set");

   property p_reset_val;
      @(posedge MCLK) $rose(NRST) |-> {chan_reg, done_reg, div_reg} == 7'h78;
   endproperty
   a_reset_val: assert property (p_reset_val)
      else $error("control reset value wrong");

   property p_div4;
      @(posedge MCLK) disable iff (!NRST)
         tick && div_reg == 2'h3 && state_reg == ADCI_BUSY
            ##1 (state_reg == ADCI_BUSY && div_reg == 2'h3) [*3] |=> tick;
   endproperty
   a_div4: assert property (p_div4)
      else $error("divide by four spacing wrong");

   c_conv: cover property (@(posedge MCLK) disable iff (!NRST)
      start_ok ##[1:200] done_edge);
   c_rej: cover property (@(posedge MCLK) disable iff (!NRST) start_rej);
   c_irq: cover property (@(posedge MCLK) disable iff (!NRST) IRQ);
   c_div4: cover property (@(posedge MCLK) disable iff (!NRST)
      tick && div_reg == 2'h3);
endmodule : adci_control

/* tb/adci_core_model.sv */
// converter core model: counts converter clock ticks and reports a result
`timescale 1ns/10ps
module adci_core_model (
   input wire logic MCLK,
   input wire logic NRST,
   input wire logic [3:0] CHANNEL,
   input wire logic POWER_DOWN,
   input wire logic CONV_START,
   input wire logic CONV_CLK_TICK,
   output logic CONV_DONE,
   output logic [9:0] CONV_RESULT
);
   // ==========================================================
   // conversion sequencing
   logic [1:0] tick_cnt;  // ticks seen in this conversion
   logic busy;  // a conversion is under way
   // result carries the routed channel so the bench can tell inputs apart
   always @(posedge MCLK) begin
      if (!NRST) begin
         busy <= 1'b0;
         CONV_DONE <= 1'b0;
         tick_cnt <= 2'h0;
         CONV_RESULT <= 10'h155;
      end else if (POWER_DOWN) begin
         busy <= 1'b0;
         CONV_DONE <= 1'b0;
      end else if (CONV_START) begin
         busy <= 1'b1;
         CONV_DONE <= 1'b0;
         tick_cnt <= 2'h0;
         CONV_RESULT <= ~CONV_RESULT;  // no stale value while busy
      end else if (busy && CONV_CLK_TICK) begin
         tick_cnt <= tick_cnt + 2'h1;
         if (tick_cnt == 2'h2) begin
            busy <= 1'b0;
            CONV_DONE <= 1'b1;
            CONV_RESULT <= {CHANNEL, 6'h15};
         end
      end
   end
endmodule : adci_core_model

/* tb/test_adc_control_interface.sv */
// self-checking bench for the converter control block
`timescale 1ns/10ps
module test_adc_control_interface;
   logic MCLK = 1'b0, NRST = 1'b0, WR = 1'b0, RD = 1'b0;
   logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA;
   logic [3:0] CHANNEL;
   logic CHAN_VALID, POWER_DOWN, CONV_START, CONV_CLK_TICK, CONV_DONE, IRQ;
   logic [9:0] CONV_RESULT;
   int failures = 0, samples_checked = 0, cyc = 0, last = 0, gap = 0;
   int starts = 0;
   // ==========================================================
   // clock, design and far side
   always #5 MCLK = ~MCLK;
   adci_control dut_u (.MCLK(MCLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA),
      .WR(WR), .RD(RD), .RDATA(RDATA), .CHANNEL(CHANNEL),
      .CHAN_VALID(CHAN_VALID), .POWER_DOWN(POWER_DOWN),
      .CONV_START(CONV_START), .CONV_CLK_TICK(CONV_CLK_TICK),
      .CONV_DONE(CONV_DONE), .CONV_RESULT(CONV_RESULT), .IRQ(IRQ));
   adci_core_model core_u (.MCLK(MCLK), .NRST(NRST), .CHANNEL(CHANNEL),
      .POWER_DOWN(POWER_DOWN), .CONV_START(CONV_START),
      .CONV_CLK_TICK(CONV_CLK_TICK), .CONV_DONE(CONV_DONE),
      .CONV_RESULT(CONV_RESULT));
   // ==========================================================
   // tick spacing and start pulse monitor
   always @(posedge MCLK) begin
      cyc++;
      if (CONV_START) begin
         starts++;
         last = 0;
      end
      if (CONV_CLK_TICK) begin
         if (last != 0) gap = cyc - last;
         last = cyc;
      end
   end
   // ==========================================================
   // bus cycles and comparison
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge MCLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge MCLK);
      WR <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge MCLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge MCLK);
      RD <= 1'b0;
      #1 d = RDATA;  // read data stand only in this cycle
   endtask : rd
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk({8'h00, d}, {8'h00, exp});
   endtask : rdchk
   // ==========================================================
   // scenarios
   task automatic t_reset;
      rdchk(8'hF7, 8'hF0);
      rdchk(8'hF9, 8'h00);
      chk({15'h0, POWER_DOWN}, 16'h0001);
      rdchk(8'h10, 8'h00);  // unmapped place reads empty
   endtask : t_reset
   // every channel, dividers in turn, with completion flag and result
   task automatic t_convert;
      logic [7:0] d;
      logic [4:0] ratio [4] = '{5'h10, 5'h0C, 5'h08, 5'h04};
      int n;
      wr(8'hFB, 8'h03);
      for (int ch = 0; ch <= 12; ch++) begin
         wr(8'hF7, {ch[3:0], 1'b0, ch[1:0], 1'b1});
         rdchk(8'hF7, {ch[3:0], 1'b0, ch[1:0], 1'b0});
         chk({12'h0, CHANNEL}, {12'h0, ch[3:0]});
         chk({15'h0, CHAN_VALID}, 16'h0001);
         n = 0;
         d = 8'h00;
         while (d[3] !== 1'b1 && n < 40) begin
            rd(8'hF7, d);
            n++;
         end
         chk({8'h00, d}, {ch[3:0], 1'b1, ch[1:0], 1'b0});
         chk(gap[15:0], {11'h0, ratio[ch % 4]});
         rdchk(8'hF8, {ch[3:0], 4'h5});
         rdchk(8'hF9, 8'h01);
         chk({15'h0, IRQ}, 16'h0001);
         wr(8'hFA, 8'h01);
         repeat (2) @(posedge MCLK);
         chk({15'h0, IRQ}, 16'h0000);
      end
   endtask : t_convert
   // disable and unassigned codes refuse a start and power down
   task automatic t_disabled;
      logic [3:0] codes [3] = '{4'hD, 4'hE, 4'hF};
      int s;
      for (int i = 0; i < 3; i++) begin
         s = starts;
         wr(8'hF7, {codes[i], 4'h1});
         repeat (3) @(posedge MCLK);
         chk({15'h0, POWER_DOWN}, 16'h0001);
         chk({15'h0, CHAN_VALID}, 16'h0000);
         chk({12'h0, CHANNEL}, 16'h0000);
         chk(starts[15:0], s[15:0]);
         rdchk(8'hFA, 8'h02);
         chk({15'h0, IRQ}, 16'h0001);
         wr(8'hFA, 8'h02);
      end
   endtask : t_disabled
   // a disable code written mid-conversion drops it unfinished
   task automatic t_abort;
      int s;
      s = starts;
      wr(8'hF7, 8'h51);
      repeat (5) @(posedge MCLK);
      chk(starts[15:0], s[15:0] + 16'h0001);
      wr(8'hF7, 8'hE0);
      repeat (3) @(posedge MCLK);
      rdchk(8'hF7, 8'hE0);
      chk({15'h0, POWER_DOWN}, 16'h0001);
   endtask : t_abort
   // a zero in the start bit selects a channel but starts nothing
   task automatic t_nostart;
      int s;
      s = starts;
      wr(8'hF7, 8'h20);
      repeat (3) @(posedge MCLK);
      chk(starts[15:0], s[15:0]);
      chk({15'h0, POWER_DOWN}, 16'h0000);
      chk({12'h0, CHANNEL}, 16'h0002);
   endtask : t_nostart
   // ==========================================================
   // verdict
   task automatic results;
      $display("comparisons %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : results
   initial begin
      #200000;
      failures++;
      results();
   end
   initial begin
      repeat (10) @(posedge MCLK);
      NRST <= 1'b1;
      t_reset();
      t_convert();
      t_disabled();
      t_abort();
      t_nostart();
      results();
   end
endmodule : test_adc_control_interface
